// ==== pkg/sfp_cfg.svh ====
/*
  Constants of the serial flash host controller: register offsets,
  field positions, reset values, flash opcodes and timing counts.
  Assumes the includer runs on a 40 MHz clk_sys.
*/
// Function
// - top_bottom_select is OTP, set only by write_status_cmd
// - dual_io_read dummy clocks: 4, or 8 if set
// - quad_io_read dummy clocks: 6, or 10 if set
// - Host polls write_in_progress before new instruction
// - read_config_cmd: opcode in, config byte out
// - Host sends write_enable_cmd before write_status_cmd
// - Chip select rises after exactly 8 or 16 bits; the host raises it after 16 or 24 bits, opcode included
// - Hardware protect left only by raising protect pin
// - Host holds protect pin high during register write
// - Address sampled on rise, data shifted on fall
// - Plain read: opcode, 3-byte address, no dummy
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// Register byte offsets on the Avalon slave
`define SFP_OFF_CTRL 5'h00
`define SFP_OFF_ADDR 5'h04
`define SFP_OFF_WDATA 5'h08
`define SFP_OFF_LEN 5'h0c
`define SFP_OFF_RDATA 5'h10
`define SFP_OFF_STAT 5'h14
`define SFP_OFF_PROT 5'h18

// Field positions
`define SFP_CTRL_TWO 3
`define SFP_CTRL_GO 4
`define SFP_CTRL_STOP 5
`define SFP_SR_WIP 0
`define SFP_CR_TB 3
`define SFP_CR_DC 6

// Reset values
`define SFP_RST_WP 1'b1
`define SFP_RST_LEN 8'h00

// Flash opcodes
`define SFP_OPC_RDSR 8'h05
`define SFP_OPC_READ_CONFIG_CMD 8'h15
`define SFP_OPC_WRITE_ENABLE_CMD 8'h06
`define SFP_OPC_WRITE_STATUS_CMD 8'h01
`define SFP_OPC_READ 8'h03

// Dummy clock counts by dummy_cycle_select
`define SFP_DUAL_DC0 4'h4
`define SFP_DUAL_DC1 4'h8
`define SFP_QUAD_DC0 4'h6
`define SFP_QUAD_DC1 4'ha

// Timing, least times rounded up to whole cycles
`define SFP_CLK_NS 25
`define SFP_SCK_HALF_NS 100
`define SFP_DESEL_NS 100
`define SFP_SCK_HALF_CYC ((`SFP_SCK_HALF_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_DESEL_CYC ((`SFP_DESEL_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)

`endif

// ==== pkg/sfp_pkg.sv ====
/*
  Types of the serial flash host controller.
  Assumes nothing of its surroundings.
*/
package sfp_pkg;

  // Operations software may start
  typedef enum logic [2:0] {
    OP_RDSR = 3'h0,
    OP_READ_CONFIG_CMD = 3'h1,
    OP_WRITE_ENABLE_CMD = 3'h2,
    OP_WRITE_STATUS_CMD = 3'h3,
    OP_READ = 3'h4
  } sfp_op_t;

  // Sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEL = 3'b001,
    ST_LOAD = 3'b011,
    ST_SHIFT = 3'b010,
    ST_NEXT = 3'b110,
    ST_DESEL = 3'b111,
    ST_WAITRD = 3'b100
  } sfp_state_t;

  // Kind of chip-select frame in flight
  typedef enum logic [1:0] {
    FR_CMD = 2'h0,
    FR_WRITE_ENABLE_CMD = 2'h1,
    FR_POLL = 2'h2
  } sfp_frame_t;

endpackage

// ==== rtl/sfp_spi_shift.sv ====
/*
  Byte shifter for the flash link, SPI mode 0, most significant bit
  first. Makes the serial clock itself by dividing clk_sys.
  Assumes miso_s is already synchronised to clk_sys.
*/
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module sfp_spi_shift #(
  parameter int unsigned HALF = `SFP_SCK_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic miso_s,
  output logic sclk,
  output logic mosi,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte
);

  logic [7:0] sh_tx; // Bits still to send
  logic [2:0] bit_cnt; // Bits finished in this byte
  logic [7:0] div; // Half-period counter
  logic half_end;

  assign half_end = (div == 8'(HALF - 1));

  // One byte: low half, rise, high half, sample and fall
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sclk <= 1'b0;
      mosi <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
      sh_tx <= 8'h00;
      bit_cnt <= 3'h0;
      div <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        // First bit set up while the clock is still low
        busy <= 1'b1;
        sh_tx <= tx_byte;
        mosi <= tx_byte[7];
        bit_cnt <= 3'h0;
        div <= 8'h00;
      end else if (busy) begin
        if (!half_end) begin
          div <= div + 8'h01;
        end else if (!sclk) begin
          div <= 8'h00;
          sclk <= 1'b1; // Device samples here
        end else begin
          // Late sample: the synchroniser lags the pin by two cycles
          div <= 8'h00;
          sclk <= 1'b0;
          rx_byte <= {rx_byte[6:0], miso_s};
          sh_tx <= {sh_tx[6:0], 1'b0};
          mosi <= sh_tx[6]; // Changes on the falling edge, or at the start of a byte
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_mosi_on_fall;
    $changed(mosi) |-> ($fell(sclk) || $rose(busy));
  endproperty
  a_mosi_on_fall: assert property (p_mosi_on_fall)
    else $error("data line moved outside a falling clock edge");

endmodule // sfp_spi_shift

// ==== rtl/sfp_host.sv ====
/*
  Host controller for a serial NOR flash: reads status and
  configuration, writes them behind a write enable with busy polling,
  and runs plain array reads stalled byte by byte by software.
  Assumes an Avalon-MM master with waitrequest on clk_sys and a flash
  wired to the SPI pins; the quad data lines are not used.
*/
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module sfp_host
  import sfp_pkg::*;
#(
  parameter int unsigned SCK_HALF = `SFP_SCK_HALF_CYC,
  parameter int unsigned DESEL_GAP = `SFP_DESEL_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic spi_wp_n,
  output logic spi_hold_n
);

  // Bus side
  logic req; // Any request present
  logic wr_acc; // Write takes effect this edge
  logic rd_acc; // Read completes this edge
  logic sel_ctrl, sel_addr, sel_wdata, sel_len;
  logic sel_rdata, sel_stat, sel_prot;
  logic [31:0] rd_mux; // Read-back selection

  // Software-visible state
  sfp_op_t op; // Operation of the current or last run
  logic two_bytes; // Status write carries a config byte
  logic [23:0] addr; // Array read start address
  logic [7:0] wdata_sr; // Status byte to write
  logic [7:0] wdata_cr; // Config byte to write
  logic [7:0] len_m1; // Read length minus one
  logic wp_level; // Protect pin level when idle
  logic [7:0] rdata; // Last array byte
  logic rdata_valid; // Array byte waiting for software
  logic next_rdata_valid;
  logic [7:0] stat_byte; // Last status byte seen
  logic [7:0] cfg_byte; // Last config byte seen
  logic busy; // Sequencer running
  logic stop_req; // Software asked to end the read

  // Sequencer
  sfp_state_t state;
  sfp_frame_t frame;
  logic [8:0] idx; // Byte within the frame
  logic [8:0] last_idx; // Index of the frame's final byte
  logic [7:0] gap_cnt; // Deselect time counter
  logic gap_end;
  logic sh_start; // Start pulse to the shifter
  logic sh_done, sh_busy;
  logic [7:0] sh_rx;
  logic [7:0] tx_sel; // Byte to shift next
  logic [7:0] opc; // Opcode of the software operation
  logic [7:0] hdr; // Opcode of the current frame
  logic [7:0] cr_keep; // Config byte with the OTP bit kept
  logic go; // Start accepted
  logic [2:0] go_op;
  logic data_byte; // Current byte is array data
  logic cap_stat, cap_cfg;
  logic [3:0] dual_dc, quad_dc; // Dummy clocks in force
  logic miso_m, miso_s; // Input synchroniser
  logic write_enable_cmd_done; // Write enable frame already sent

  // Address decode
  assign req = avs_read | avs_write;
  assign wr_acc = avs_write & ~avs_waitrequest;
  assign rd_acc = avs_read & ~avs_waitrequest;
  assign sel_ctrl = (avs_address == `SFP_OFF_CTRL);
  assign sel_addr = (avs_address == `SFP_OFF_ADDR);
  assign sel_wdata = (avs_address == `SFP_OFF_WDATA);
  assign sel_len = (avs_address == `SFP_OFF_LEN);
  assign sel_rdata = (avs_address == `SFP_OFF_RDATA);
  assign sel_stat = (avs_address == `SFP_OFF_STAT);
  assign sel_prot = (avs_address == `SFP_OFF_PROT);

  // Start only idle and only with a known operation
  assign go_op = avs_writedata[2:0];
  assign go = wr_acc & sel_ctrl & avs_writedata[`SFP_CTRL_GO] & ~busy
    & (go_op <= 3'h4);

  // Dummy clocks that the fast reads would need, reported to software
  assign dual_dc = cfg_byte[`SFP_CR_DC] ? `SFP_DUAL_DC1 : `SFP_DUAL_DC0;
  assign quad_dc = cfg_byte[`SFP_CR_DC] ? `SFP_QUAD_DC1 : `SFP_QUAD_DC0;

  // Read-back; unmapped offsets answer zero
  assign rd_mux = sel_ctrl ? {28'h0000000, two_bytes, op} :
    sel_addr ? {8'h00, addr} :
    sel_wdata ? {16'h0000, wdata_cr, wdata_sr} :
    sel_len ? {24'h000000, len_m1} :
    sel_rdata ? {24'h000000, rdata} :
    sel_stat ? {quad_dc, dual_dc, cfg_byte, stat_byte, 6'h00, rdata_valid, busy} :
    sel_prot ? {31'h00000000, wp_level} : 32'h00000000;

  // One wait cycle, then the answer; waitrequest rises again after it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Software registers; settings are frozen while a run is going
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      op <= OP_RDSR;
      two_bytes <= 1'b0;
      addr <= 24'h000000;
      wdata_sr <= 8'h00;
      wdata_cr <= 8'h00;
      len_m1 <= `SFP_RST_LEN;
      wp_level <= `SFP_RST_WP;
    end else if (wr_acc && !busy) begin
      if (sel_ctrl && go_op <= 3'h4) begin
        op <= sfp_op_t'(go_op);
        two_bytes <= avs_writedata[`SFP_CTRL_TWO];
      end
      if (sel_addr) begin
        addr <= avs_writedata[23:0];
      end
      if (sel_wdata) begin
        wdata_sr <= avs_writedata[7:0];
        wdata_cr <= avs_writedata[15:8];
      end
      if (sel_len) begin
        len_m1 <= avs_writedata[7:0];
      end
      if (sel_prot) begin
        wp_level <= avs_writedata[0]; // Pin level sets the device's mode
      end
    end
  end

  // Stop request, sticky until the sequencer is idle again
  always_ff @(posedge clk_sys) begin
    if (!resetn || state == ST_IDLE) begin
      stop_req <= 1'b0;
    end else if (wr_acc && sel_ctrl && avs_writedata[`SFP_CTRL_STOP]) begin
      stop_req <= 1'b1;
    end
  end

  // Byte valid flag; a new byte wins over a software read
  assign data_byte = (frame == FR_CMD) && (op == OP_READ) && (idx >= 9'd4);
  assign next_rdata_valid = ((state == ST_NEXT) && data_byte)
    | (rdata_valid & ~(rd_acc & sel_rdata));

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= next_rdata_valid;
    end
  end

  // Frame length; a status write ends on a whole byte
  assign last_idx = (frame == FR_WRITE_ENABLE_CMD) ? 9'd0 :
    (frame == FR_POLL) ? 9'd1 :
    (op == OP_WRITE_ENABLE_CMD) ? 9'd0 :
    (op == OP_WRITE_STATUS_CMD) ? ({8'h00, two_bytes} + 9'd1) :
    (op == OP_READ) ? ({1'b0, len_m1} + 9'd4) : 9'd1;

  // Opcode selection
  assign opc = (op == OP_RDSR) ? `SFP_OPC_RDSR :
    (op == OP_READ_CONFIG_CMD) ? `SFP_OPC_READ_CONFIG_CMD :
    (op == OP_WRITE_ENABLE_CMD) ? `SFP_OPC_WRITE_ENABLE_CMD :
    (op == OP_WRITE_STATUS_CMD) ? `SFP_OPC_WRITE_STATUS_CMD : `SFP_OPC_READ;
  assign hdr = (frame == FR_WRITE_ENABLE_CMD) ? `SFP_OPC_WRITE_ENABLE_CMD :
    (frame == FR_POLL) ? `SFP_OPC_RDSR : opc;

  // Never try to clear a top/bottom bit seen set in the last config read
  assign cr_keep = wdata_cr | (cfg_byte & (8'h01 << `SFP_CR_TB));

  // Outgoing byte: opcode, then status and config, or the address
  assign tx_sel = (idx == 9'd0) ? hdr :
    (frame != FR_CMD) ? 8'h00 :
    (op == OP_WRITE_STATUS_CMD) ? ((idx == 9'd1) ? wdata_sr : cr_keep) :
    (op != OP_READ) ? 8'h00 :
    (idx == 9'd1) ? addr[23:16] :
    (idx == 9'd2) ? addr[15:8] :
    (idx == 9'd3) ? addr[7:0] : 8'h00;

  assign gap_end = (gap_cnt == 8'(DESEL_GAP - 1));

  // Frame sequencer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= ST_IDLE;
      frame <= FR_CMD;
      idx <= 9'd0;
      gap_cnt <= 8'h00;
      sh_start <= 1'b0;
      spi_cs_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      sh_start <= 1'b0;
      case (state)
        ST_IDLE: if (go) begin
          busy <= 1'b1;
          // Latch must be set first
          frame <= (go_op == 3'(OP_WRITE_STATUS_CMD)) ? FR_WRITE_ENABLE_CMD : FR_CMD;
          state <= ST_SEL;
        end
        ST_SEL: begin
          spi_cs_n <= 1'b0;
          idx <= 9'd0;
          state <= ST_LOAD;
        end
        ST_LOAD: begin
          sh_start <= 1'b1;
          state <= ST_SHIFT;
        end
        ST_SHIFT: if (sh_done) begin
          state <= ST_NEXT;
        end
        ST_NEXT: if (idx == last_idx) begin
          spi_cs_n <= 1'b1; // Only after a whole byte
          gap_cnt <= 8'h00;
          state <= ST_DESEL;
        end else begin
          idx <= idx + 9'd1;
          // Stall the link clock until software takes the byte
          state <= data_byte ? ST_WAITRD : ST_LOAD;
        end
        ST_WAITRD: if (stop_req) begin
          spi_cs_n <= 1'b1; // Ending a read anywhere is allowed
          gap_cnt <= 8'h00;
          state <= ST_DESEL;
        end else if (!rdata_valid) begin
          state <= ST_LOAD;
        end
        ST_DESEL: if (!gap_end) begin
          gap_cnt <= gap_cnt + 8'h01;
        end else if (frame == FR_WRITE_ENABLE_CMD) begin
          frame <= FR_CMD;
          state <= ST_SEL;
        end else if (op == OP_WRITE_STATUS_CMD &&
                     (frame == FR_CMD || stat_byte[`SFP_SR_WIP])) begin
          // Poll busy until the self-timed write is over
          frame <= FR_POLL;
          state <= ST_SEL;
        end else begin
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Capture of answers at the end of each byte
  assign cap_stat = (idx == 9'd1) &&
    (frame == FR_POLL || (frame == FR_CMD && op == OP_RDSR));
  assign cap_cfg = (idx == 9'd1) && (frame == FR_CMD) && (op == OP_READ_CONFIG_CMD);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stat_byte <= 8'h00;
      cfg_byte <= 8'h00;
      rdata <= 8'h00;
    end else if (state == ST_NEXT) begin
      if (cap_stat) begin
        stat_byte <= sh_rx;
      end
      if (cap_cfg) begin
        cfg_byte <= sh_rx; // Config byte arrives after the opcode
      end
      if (data_byte) begin
        rdata <= sh_rx;
      end
    end
  end

  // Protect pin forced high for the whole register write
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      spi_wp_n <= `SFP_RST_WP;
      spi_hold_n <= 1'b1;
    end else begin
      spi_wp_n <= wp_level | (busy & (op == OP_WRITE_STATUS_CMD));
      spi_hold_n <= 1'b1; // Hold is never used
    end
  end

  // Data-in synchroniser
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      miso_m <= spi_miso;
      miso_s <= miso_m;
    end
  end

  // Write enable frame seen in this run
  always_ff @(posedge clk_sys) begin
    if (!resetn || state == ST_IDLE) begin
      write_enable_cmd_done <= 1'b0;
    end else if (state == ST_DESEL && frame == FR_WRITE_ENABLE_CMD) begin
      write_enable_cmd_done <= 1'b1;
    end
  end

  // Link shifter
  sfp_spi_shift #(
    .HALF(SCK_HALF)
  ) u_shift (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(sh_start),
    .tx_byte(tx_sel),
    .miso_s(miso_s),
    .sclk(spi_sclk),
    .mosi(spi_mosi),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(sh_rx)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_write_enable_cmd_first;
    (state == ST_LOAD && frame == FR_CMD && op == OP_WRITE_STATUS_CMD && idx == 9'd0)
      |-> write_enable_cmd_done;
  endproperty
  a_write_enable_cmd_first: assert property (p_write_enable_cmd_first)
    else $error("status write sent without write enable");

  property p_write_status_cmd_len;
    ($rose(spi_cs_n) && frame == FR_CMD && op == OP_WRITE_STATUS_CMD)
      |-> (idx == ({8'h00, two_bytes} + 9'd1));
  endproperty
  a_write_status_cmd_len: assert property (p_write_status_cmd_len)
    else $error("status write ended off a byte boundary");

  property p_cs_whole_byte;
    $rose(spi_cs_n) |-> !sh_busy;
  endproperty
  a_cs_whole_byte: assert property (p_cs_whole_byte)
    else $error("chip select raised inside a byte");

  property p_wp_high;
    (busy && op == OP_WRITE_STATUS_CMD) ##1 busy |-> spi_wp_n;
  endproperty
  a_wp_high: assert property (p_wp_high)
    else $error("protect pin low during register write");

  property p_poll_after;
    (state == ST_DESEL && gap_end && frame == FR_CMD && op == OP_WRITE_STATUS_CMD)
      |=> (frame == FR_POLL && state == ST_SEL);
  endproperty
  a_poll_after: assert property (p_poll_after)
    else $error("no busy poll after status write");

  property p_tb_kept;
    (state == ST_LOAD && frame == FR_CMD && op == OP_WRITE_STATUS_CMD && idx == 9'd2
      && cfg_byte[`SFP_CR_TB]) |-> tx_sel[`SFP_CR_TB];
  endproperty
  a_tb_kept: assert property (p_tb_kept)
    else $error("attempt to clear the one-time bit");

  property p_sr_first;
    (state == ST_LOAD && frame == FR_CMD && op == OP_WRITE_STATUS_CMD && idx == 9'd1)
      |-> (tx_sel == wdata_sr);
  endproperty
  a_sr_first: assert property (p_sr_first)
    else $error("first written byte is not the status byte");

  property p_no_dummy;
    (state == ST_NEXT && frame == FR_CMD && op == OP_READ && idx == 9'd4)
      |=> (rdata_valid && rdata == $past(sh_rx));
  endproperty
  a_no_dummy: assert property (p_no_dummy)
    else $error("read data not taken right after the address");

  property p_read_config_cmd_cap;
    (state == ST_NEXT && cap_cfg) |=> (cfg_byte == $past(sh_rx));
  endproperty
  a_read_config_cmd_cap: assert property (p_read_config_cmd_cap)
    else $error("config byte not captured");

  property p_dual_dc;
    (avs_read && avs_waitrequest && sel_stat) |=> (avs_readdata[27:24] ==
      ($past(cfg_byte[`SFP_CR_DC]) ? `SFP_DUAL_DC1 : `SFP_DUAL_DC0));
  endproperty
  a_dual_dc: assert property (p_dual_dc)
    else $error("wrong dual read dummy count");

  property p_quad_dc;
    (avs_read && avs_waitrequest && sel_stat) |=> (avs_readdata[31:28] ==
      ($past(cfg_byte[`SFP_CR_DC]) ? `SFP_QUAD_DC1 : `SFP_QUAD_DC0));
  endproperty
  a_quad_dc: assert property (p_quad_dc)
    else $error("wrong quad read dummy count");

  // Main scenarios
  c_poll: cover property (state == ST_SEL && frame == FR_POLL);
  c_stall: cover property (state == ST_WAITRD ##1 state == ST_LOAD);
  c_stop: cover property (state == ST_WAITRD && stop_req);
  c_read_config_cmd: cover property (state == ST_NEXT && cap_cfg);

endmodule // sfp_host

// ==== verif/sfp_flash_model.sv ====
/*
  Behavioural serial NOR flash: status, config, write enable,
  status write with self-timed busy, plain array read.
  Assumes a mode 0 host that makes the serial clock.
*/
`timescale 1ns/1ps

module sfp_flash_model #(
  parameter int WRITE_NS = 10000 // status_write_time, kept short
) (
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic spi_wp_n,
  input wire logic spi_hold_n,
  output logic [7:0] sr,
  output logic [7:0] cr,
  output int proto_err
);
  logic [31:0] shreg; // Bits in, newest last
  logic [23:0] addr; // Read start address
  logic [7:0] op; // Opcode of this frame
  logic [7:0] b; // Byte being sent
  int nbit; // Rising edges in frame
  int idx; // Bit index of output
  event wr_ev; // Starts the timed write
  // Blank device, nothing protected
  initial begin
    sr = 8'h00;
    cr = 8'h00;
    spi_miso = 1'b0;
    proto_err = 0;
    nbit = 0;
    op = 8'h00;
  end
  always @(negedge spi_cs_n) nbit = 0;
  // Inputs taken on the rise
  always @(posedge spi_sclk) if (!spi_cs_n) begin
    shreg = {shreg[30:0], spi_mosi};
    nbit++;
    if (nbit == 8) begin
      op = shreg[7:0];
      // Only status and config reads are welcome while busy
      if (sr[0] && op != 8'h05 && op != 8'h15) proto_err++;
    end
    if (nbit == 32) addr = shreg[23:0];
  end
  // Outputs change on the fall; read address wraps with 24 bits
  always @(negedge spi_sclk) if (!spi_cs_n) begin
    idx = nbit - ((op == 8'h03) ? 32 : 8);
    if (idx >= 0) begin
      b = (op == 8'h05) ? sr : (op == 8'h15) ? cr : 8'ha5;
      if (op == 8'h03) b = 8'(addr + 24'(idx / 8)) + 8'((addr + 24'(idx / 8)) >> 16);
      spi_miso = b[7 - idx % 8];
    end
  end
  // Frame end: released line shows a changed level, no pull
  always @(posedge spi_cs_n) begin
    spi_miso = ~spi_miso;
    if (op == 8'h06 && nbit == 8 && !sr[0]) sr[1] = 1'b1;
    if (op == 8'h01 && nbit >= 8) begin
      if (!sr[1]) proto_err++;
      // Latch, count, idle and protect pin all gate the write
      if (sr[1] && !sr[0] && (nbit == 16 || nbit == 24) && !(sr[7] && !spi_wp_n)) begin
        b = (nbit == 16) ? shreg[7:0] : shreg[15:8];
        sr[7:2] = b[7:2];
        if (nbit == 24) cr = {cr[7], shreg[6], cr[5:4], cr[3] | shreg[3], cr[2:0]};
        ->wr_ev;
      end
    end
  end
  // Self-timed write: busy, then latch cleared
  always begin
    @(wr_ev);
    sr[0] = 1'b1;
    #(WRITE_NS);
    sr[0] = 1'b0;
    sr[1] = 1'b0;
  end
  // Protect pin must stay high during a guarded write
  always @(negedge spi_wp_n) if (sr[0] && sr[7]) proto_err++;
endmodule // sfp_flash_model

// ==== verif/tb.sv ====
/*
  Self-checking bench of the flash host over Avalon-MM.
  Assumes sfp_host and the flash model are compiled beside it.
*/
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_wp_n, spi_hold_n;
  logic [7:0] sr, cr;
  logic [7:0] exp_rd [4] = '{8'hfd, 8'hfe, 8'h00, 8'h01};
  int proto_err;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;
  sfp_host #(.SCK_HALF(4), .DESEL_GAP(4)) dut (.clk_sys(clk_sys), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_wp_n(spi_wp_n), .spi_hold_n(spi_hold_n));
  sfp_flash_model flash (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_wp_n(spi_wp_n), .spi_hold_n(spi_hold_n), .sr(sr), .cr(cr),
    .proto_err(proto_err));
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      mismatches++;
    end
  endtask
  // One transfer held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Start an operation, poll until idle; q keeps last status
  task automatic run(input logic [2:0] op, input logic two);
    av(1'b1, `SFP_OFF_CTRL, 32'(op) | (32'(two) << `SFP_CTRL_TWO) | (32'h1 << `SFP_CTRL_GO));
    do av(1'b0, `SFP_OFF_STAT, 32'h0); while (q[0] !== 1'b0);
  endtask
  task automatic write_status_cmd(input logic [15:0] d, input logic two);
    av(1'b1, `SFP_OFF_WDATA, {16'h0, d});
    run(3'h3, two);
  endtask
  // Reset values, unmapped place, default dummy counts
  task automatic t_reset();
    chk("wp_n", 32'h1, 32'(spi_wp_n));
    av(1'b0, `SFP_OFF_PROT, 32'h0);
    chk("prot", 32'h1, q);
    av(1'b1, 5'h1c, 32'hffffffff);
    av(1'b0, 5'h1c, 32'h0);
    chk("unmapped", 32'h0, q);
    run(3'h1, 1'b0);
    chk("cfg", 32'h0, 32'(q[23:16]));
    chk("dual", 32'h4, 32'(q[27:24]));
    chk("quad", 32'h6, 32'(q[31:28]));
    run(3'h0, 1'b0);
    chk("status", 32'h0, 32'(q[15:8]));
  endtask
  // Two-byte writes, then a one-byte write; latch and busy bits not writable, OTP bit sticks
  task automatic t_two();
    run(3'h2, 1'b0);
    chk("wel", 32'h1, 32'(sr[1]));
    write_status_cmd(16'h483f, 1'b1);
    chk("sr", 32'h3c, 32'(sr));
    chk("cr", 32'h48, 32'(cr));
    run(3'h1, 1'b0);
    chk("dual", 32'h8, 32'(q[27:24]));
    chk("quad", 32'ha, 32'(q[31:28]));
    write_status_cmd(16'h0000, 1'b1);
    chk("cr otp", 32'h08, 32'(cr));
    write_status_cmd(16'h401c, 1'b0);
    chk("sr one", 32'h1c, 32'(sr));
    chk("cr one", 32'h08, 32'(cr));
  endtask
  // Disable bit set, pin high during write keeps it writable
  task automatic t_prot();
    write_status_cmd(16'h0080, 1'b0);
    av(1'b1, `SFP_OFF_PROT, 32'h0);
    av(1'b0, `SFP_OFF_PROT, 32'h0);
    chk("wp_n low", 32'h0, 32'(spi_wp_n));
    write_status_cmd(16'h0000, 1'b0);
    chk("sr clr", 32'h00, 32'(sr));
    av(1'b1, `SFP_OFF_PROT, 32'h1);
  endtask
  // Array read across the top address; LEN refused while busy
  task automatic t_read();
    av(1'b1, `SFP_OFF_ADDR, 32'hfffffe);
    av(1'b1, `SFP_OFF_LEN, 32'h3);
    av(1'b1, `SFP_OFF_CTRL, 32'h4 | (32'h1 << `SFP_CTRL_GO));
    av(1'b1, `SFP_OFF_LEN, 32'h0);
    for (int k = 0; k < 4; k++) begin
      do av(1'b0, `SFP_OFF_STAT, 32'h0); while (q[1] !== 1'b1);
      av(1'b0, `SFP_OFF_RDATA, 32'h0);
      chk("rdata", 32'(exp_rd[k]), 32'(q[7:0]));
    end
    do av(1'b0, `SFP_OFF_STAT, 32'h0); while (q[0] !== 1'b0);
    av(1'b0, `SFP_OFF_LEN, 32'h0);
    chk("len", 32'h3, q);
  endtask
  // Read cut short by stop after its first byte
  task automatic t_stop();
    av(1'b1, `SFP_OFF_ADDR, 32'h010203);
    av(1'b1, `SFP_OFF_CTRL, 32'h4 | (32'h1 << `SFP_CTRL_GO));
    do av(1'b0, `SFP_OFF_STAT, 32'h0); while (q[1] !== 1'b1);
    av(1'b1, `SFP_OFF_CTRL, 32'h1 << `SFP_CTRL_STOP);
    do av(1'b0, `SFP_OFF_STAT, 32'h0); while (q[0] !== 1'b0);
    av(1'b0, `SFP_OFF_RDATA, 32'h0);
    chk("stop rdata", 32'h04, 32'(q[7:0]));
    av(1'b0, `SFP_OFF_STAT, 32'h0);
    chk("stop valid", 32'h0, 32'(q[1:0]));
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_two();
    t_prot();
    t_read();
    t_stop();
    chk("proto", 32'h0, 32'(proto_err));
    wrap_up();
  end
endmodule // tb
